// ---- bench/bes_core_checker.sv ----
`timescale 1ns/1ps
module bes_core_checker #(
	parameter ADDR_W = 32
) (
	// observed ports
	input wire clk_sys_in,
	input wire reset_in,
	input wire bus_error_ack_in,
	input wire data_bus_busy_out,
	input wire data_bus_busy_oe_n_out,
	input wire txn_done_out,
	input wire transfer_start_out,
	input wire transfer_start_oe_n_out,
	input wire transfer_start_in,
	input wire global_indication_in,
	input wire addr_oe_n_out,
	input wire [ADDR_W-1:0] addr_in,
	input wire [ADDR_W-1:0] snoop_addr_out,
	input wire snoop_lookup_out,
	input wire snoop_hit_in,
	input wire snoop_modified_in,
	input wire address_retry_out,
	input wire address_retry_oe_n_out,
	input wire tt_oe_n_out,
	input wire global_indication_oe_n_out,
	input wire snoop_inval_out,
	input wire machine_check_out,
	input wire checkstop_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	// data tenure end and exceptions
	property p_err_end; bus_error_ack_in && data_bus_busy_out |=> !data_bus_busy_out && txn_done_out; endproperty
	a_err_end: assert property (p_err_end) else $error("tenure not ended by bus error");
	property p_halt; machine_check_out || checkstop_out |-> !transfer_start_out; endproperty
	a_halt: assert property (p_halt) else $error("transaction started after bus error");
	property p_cstop; checkstop_out |-> !machine_check_out; endproperty
	a_cstop: assert property (p_cstop) else $error("checkstop with machine check");
	// snoop qualification
	property p_snp; transfer_start_in && global_indication_in && addr_oe_n_out
		|=> snoop_lookup_out && snoop_addr_out == $past(addr_in); endproperty
	a_snp: assert property (p_snp) else $error("qualified snoop not looked up");
	property p_nosnp; !(transfer_start_in && global_indication_in) |=> !snoop_lookup_out; endproperty
	a_nosnp: assert property (p_nosnp) else $error("lookup without qualified snoop");
	property p_retry; snoop_lookup_out && snoop_hit_in && snoop_modified_in |=> address_retry_out; endproperty
	a_retry: assert property (p_retry) else $error("no retry on modified hit");
	property p_miss; snoop_lookup_out && !snoop_hit_in |=> !address_retry_out; endproperty
	a_miss: assert property (p_miss) else $error("retry on snoop miss");
	property p_inval; snoop_lookup_out && snoop_hit_in |=> snoop_inval_out; endproperty
	a_inval: assert property (p_inval) else $error("snoop hit did not invalidate");
	property p_noinval; !snoop_lookup_out |=> !snoop_inval_out; endproperty
	a_noinval: assert property (p_noinval) else $error("cache changed without qualified snoop");
	// pin release between tenures
	property p_ts_oe; transfer_start_oe_n_out != transfer_start_out; endproperty
	a_ts_oe: assert property (p_ts_oe) else $error("start pin enable wrong");
	property p_dbb_oe; data_bus_busy_out |-> !data_bus_busy_oe_n_out; endproperty
	a_dbb_oe: assert property (p_dbb_oe) else $error("busy not driven");
	property p_drive; transfer_start_out
		|-> !addr_oe_n_out && !tt_oe_n_out && !global_indication_oe_n_out; endproperty
	a_drive: assert property (p_drive) else $error("address tenure pins not driven");
	property p_release; !transfer_start_out
		|-> addr_oe_n_out && tt_oe_n_out && global_indication_oe_n_out; endproperty
	a_release: assert property (p_release) else $error("address pins not released");
	property p_ar_oe; address_retry_oe_n_out != address_retry_out; endproperty
	a_ar_oe: assert property (p_ar_oe) else $error("retry pin enable wrong");
endmodule // bes_core_checker
bind bes_core bes_core_checker #(.ADDR_W(ADDR_W)) u_chk (.clk_sys_in, .reset_in, .bus_error_ack_in,
	.data_bus_busy_out, .data_bus_busy_oe_n_out, .txn_done_out, .transfer_start_out, .transfer_start_oe_n_out,
	.transfer_start_in, .global_indication_in, .addr_oe_n_out, .addr_in, .snoop_addr_out, .snoop_lookup_out,
	.snoop_hit_in, .snoop_modified_in, .address_retry_out, .address_retry_oe_n_out, .tt_oe_n_out,
	.global_indication_oe_n_out, .snoop_inval_out, .machine_check_out, .checkstop_out);

// ---- bench/bes_sys_model.sv ----
`timescale 1ns/1ps
module bes_sys_model (
	// bus side
	input wire clk_sys_in,
	input wire reset_in,
	input wire transfer_start_out,
	input wire burst_out,
	output reg data_bus_grant_in,
	output reg transfer_ack_in,
	output reg data_retry_in,
	output reg bus_error_ack_in,
	// scenario control
	input wire [2:0] err_beat_in,
	input wire [2:0] retry_beat_in,
	input wire [1:0] wait_in
);
	integer n;
	integer i;
	// grant, pace beats, then finish normally or by bus error
	initial
	begin
		{data_bus_grant_in, transfer_ack_in, data_retry_in, bus_error_ack_in} = 4'h0;
		forever
		begin
			@(posedge clk_sys_in);
			if (!reset_in && transfer_start_out)
			begin
				n = burst_out ? 4 : 1;
				repeat (wait_in) @(posedge clk_sys_in);
				data_bus_grant_in <= 1'b1;
				@(posedge clk_sys_in);
				data_bus_grant_in <= 1'b0;
				for (i = 1; i <= n; i = i + 1)
				begin
					repeat (wait_in + 1) @(posedge clk_sys_in);
					if (i == err_beat_in)
					begin
						bus_error_ack_in <= 1'b1;
						@(posedge clk_sys_in);
						bus_error_ack_in <= 1'b0;
						i = n;
					end
					transfer_ack_in <= 1'b1;
					@(posedge clk_sys_in);
					transfer_ack_in <= 1'b0;
					data_retry_in <= (i == retry_beat_in);
					@(posedge clk_sys_in);
					data_retry_in <= 1'b0;
				end
			end
		end
	end
endmodule // bes_sys_model

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "bes_defines.vh"
module tb_top;
	logic clk_sys_in, reset_in, wb_cyc_in, wb_stb_in, wb_we_in, req_valid_in, req_read_in, req_burst_in;
	logic req_read_with_intent_to_modify_in, req_coherent_in, req_no_tlb_in, req_clean_hit_in, global_indication_in, transfer_start_in;
	logic snoop_hit_in, snoop_modified_in;
	logic [3:0] wb_adr_in, wb_sel_in;
	logic [31:0] wb_dat_in, req_addr_in, addr_in, r;
	logic [2:0] req_way_in, err_b, rty_b;
	logic [1:0] wt;
	wire data_bus_grant_in, transfer_ack_in, data_retry_in, bus_error_ack_in, wb_ack_out, addr_oe_n_out;
	wire transfer_start_out, transfer_start_oe_n_out, tt_oe_n_out, burst_out, global_indication_out;
	wire global_indication_oe_n_out, address_retry_out, address_retry_oe_n_out, data_bus_busy_out;
	wire data_bus_busy_oe_n_out, beat_valid_out, txn_done_out, snoop_lookup_out, snoop_inval_out;
	wire machine_check_out, checkstop_out;
	wire [31:0] wb_dat_out, addr_out, snoop_addr_out;
	wire [3:0] transfer_type_bits_out;
	wire [2:0] replaced_way_code_out;
	logic [43:0] q[$];
	logic [40:0] got;
	int nb, dly, c, n_mismatch, cmp_count;
	bes_core uut (.*);
	bes_sys_model sys (.*, .err_beat_in(err_b), .retry_beat_in(rty_b), .wait_in(wt));
	initial
	begin
		clk_sys_in = 0;
		forever #50 clk_sys_in = ~clk_sys_in;
	end
	task check(input logic [43:0] g, input logic [43:0] e);
		cmp_count++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask
	task finish_test;
		if (q.size() != 0)
		begin
			n_mismatch++;
			$display("BAD %0t %0d notes never matched", $time, q.size());
		end
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		{wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'h3, we, a, d};
		do @(posedge clk_sys_in); while (wb_ack_out !== 1'b1);
		r = wb_dat_out;
		{wb_cyc_in, wb_stb_in} <= 2'h0;
		@(posedge clk_sys_in);
	endtask
	task rst;
		reset_in <= 1'b1;
		repeat (10) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		@(posedge clk_sys_in);
	endtask
	// f = read, burst, read_with_intent_to_modify, coherent, no_tlb, clean_hit
	task txn(input logic [5:0] f, input logic [2:0] eb, input logic [2:0] rb);
		logic [31:0] a;
		logic [2:0] w;
		logic [3:0] tt;
		logic s;
		int t;
		a = $urandom;
		w = $urandom;
		t = 0;
		{err_b, rty_b, wt} <= {eb, rb, 2'($urandom)};
		{req_read_in, req_burst_in, req_read_with_intent_to_modify_in, req_coherent_in, req_no_tlb_in, req_clean_hit_in} <= f;
		{req_addr_in, req_way_in, req_valid_in} <= {a, w, 1'b1};
		tt = !f[5] ? `BES_TT_WRITE_SB : f[3] ? `BES_TT_READ_WITH_INTENT_TO_MODIFY : `BES_TT_READ;
		if (f[5] || !f[0] || f[2])
			q.push_back({a, tt, f[2] & !f[1], f[4], f[5] & f[4] ? w : 3'h0,
				!f[5] ? 3'h0 : eb != 0 ? eb - 3'h1 : f[4] ? 3'h4 : 3'h1});
		do @(posedge clk_sys_in); while (!transfer_start_out && ++t < 20);
		s = transfer_start_out;
		req_valid_in <= 1'b0;
		check(s, f[5] || !f[0] || f[2]);
		t = 0;
		while (s && !txn_done_out && ++t < 100)
			@(posedge clk_sys_in);
		if (s && !txn_done_out)
		begin
			n_mismatch++;
			$display("BAD %0t transaction never finished", $time);
		end
		repeat (8) @(posedge clk_sys_in);
	endtask
	task snoop(input logic g, input logic h, input logic m);
		logic [31:0] a;
		a = $urandom;
		{err_b, rty_b, snoop_hit_in, snoop_modified_in} <= {6'h0, h, m};
		{transfer_start_in, global_indication_in, addr_in} <= {1'b1, g, a};
		if (g & h & m)
			q.push_back({a, `BES_TT_PUSH, 1'b0, 1'b1, 6'h0});
		@(posedge clk_sys_in);
		{transfer_start_in, global_indication_in, addr_in} <= {2'h0, ~a};
		repeat (40) @(posedge clk_sys_in);
	endtask
	// capture each transaction and compare it with the oldest note
	always @(posedge clk_sys_in)
	begin
		if (transfer_start_out)
			{got, nb} <= {addr_out, transfer_type_bits_out, global_indication_out, burst_out, replaced_way_code_out, 32'h0};
		else if (beat_valid_out)
			nb <= nb + 1;
		dly <= txn_done_out ? 6 : dly > 0 ? dly - 1 : 0;
		if (dly == 1)
		begin
			if (q.size() == 0)
			begin
				n_mismatch++;
				$display("BAD %0t transaction without a note", $time);
			end
			else
				check({got, nb[2:0]}, q.pop_front());
		end
	end
	initial
	begin
		#500000;
		n_mismatch++;
		finish_test;
	end
	initial
	begin
		{reset_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_sel_in, wb_dat_in} = {4'h8, 4'h0, 4'hF, 32'h0};
		{req_valid_in, req_read_in, req_burst_in, req_read_with_intent_to_modify_in, req_coherent_in, req_no_tlb_in} = 6'h0;
		{req_clean_hit_in, req_way_in, req_addr_in, addr_in, err_b, rty_b, wt} = 0;
		{global_indication_in, transfer_start_in, snoop_hit_in, snoop_modified_in, dly} = 0;
		void'($urandom(32768));
		rst;
		txn(6'b100000, 3'h0, 3'h0);
		txn(6'b110100, 3'h0, 3'h3);
		txn(6'b111100, 3'h0, 3'h0);
		txn(6'b000101, 3'h0, 3'h0);
		txn(6'b000001, 3'h0, 3'h0);
		txn(6'b000110, 3'h0, 3'h1);
		for (c = 0; c < 8; c++)
			snoop(c[2], c[1], c[0]);
		wb(1'b0, 4'h2, 32'h0);
		check(r, 0);
		for (c = 0; c < 4; c++)
		begin
			rst;
			wb(1'b0, `BES_REG_CTRL, 32'h0);
			check(r, `BES_CTRL_RST);
			wb(1'b1, `BES_REG_CTRL, c);
			wb(1'b0, `BES_REG_CTRL, 32'h0);
			check(r, c);
			txn(6'b110100, 3'h2, 3'h0);
			check({machine_check_out, checkstop_out}, {c[0] & !c[1], c[1]});
			wb(1'b0, `BES_REG_STATUS, 32'h0);
			check(r, {2'h1, c[1], c[0] & !c[1]});
		end
		finish_test;
	end
endmodule // tb_top

// ---- design/bes_core.v ----
// Functional notes
// - bus error ends tenure, ignores later acks
// - bus error raises machine check or checkstop (code raises neither when both control enables are clear)
// - machine check enable gates; checkstop enable overrides
// - already delivered data is never invalidated
// - faulting address is not captured
// - error report is asynchronous, not precise
// - global follows translation coherency bit
// - snoop only when start and global coincide
// - non-global snoop never changes cache
// - qualified snoop compares tags, hit follows MESI
// - store to clean non-global line no broadcast
// - copy-back, push, table search driven non-global (code does so for the snoop push only)
// - reads output three-bit replaced way code
// - way code valid only during bursts
// - bidirectional signals released between tenures
// - single-beat write type pattern x001
// - data retry ignored for write transfers
// - burst read first beat is critical quad
//
// Added by the designer: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "bes_defines.vh"
module bes_core #(
	parameter ADDR_W = 32
) (
	// clock and reset
	input wire clk_sys_in,
	input wire reset_in,
	// wishbone slave
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [3:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output reg [31:0] wb_dat_out,
	output reg wb_ack_out,
	// request from core side
	input wire req_valid_in,
	input wire req_read_in,
	input wire req_burst_in,
	input wire req_read_with_intent_to_modify_in,
	input wire req_coherent_in,
	input wire req_no_tlb_in,
	input wire req_clean_hit_in,
	input wire [2:0] req_way_in,
	input wire [ADDR_W-1:0] req_addr_in,
	// bus address side
	output reg [ADDR_W-1:0] addr_out,
	output reg addr_oe_n_out,
	output reg transfer_start_out,
	output reg transfer_start_oe_n_out,
	output reg [3:0] transfer_type_bits_out,
	output reg tt_oe_n_out,
	output reg burst_out,
	output reg global_indication_out,
	output reg global_indication_oe_n_out,
	input wire global_indication_in,
	input wire transfer_start_in,
	input wire [ADDR_W-1:0] addr_in,
	output reg address_retry_out,
	output reg address_retry_oe_n_out,
	output reg [2:0] replaced_way_code_out,
	// bus data tenure
	input wire data_bus_grant_in,
	input wire transfer_ack_in,
	input wire data_retry_in,
	input wire bus_error_ack_in,
	output reg data_bus_busy_out,
	output reg data_bus_busy_oe_n_out,
	output reg beat_valid_out,
	output reg txn_done_out,
	// snoop tag port
	output reg snoop_lookup_out,
	output reg [ADDR_W-1:0] snoop_addr_out,
	input wire snoop_hit_in,
	input wire snoop_modified_in,
	output reg snoop_inval_out,
	// exception side
	output reg machine_check_out,
	output reg checkstop_out
);
	// sequencer states; a snoop push waits for its data grant in S_PUSHD
	localparam S_IDLE = 3'h0;
	localparam S_ADDR = 3'h1;
	localparam S_WAITDG = 3'h2;
	localparam S_DATA = 3'h3;
	localparam S_PUSHA = 3'h4;
	localparam S_PUSHD = 3'h5;

	// sequencer, tenure, error and snoop state
	reg [2:0] state_ff, nxt_state;
	reg [1:0] ctrl_ff;
	reg err_ff;
	reg rd_ff;
	reg [2:0] beats_ff;
	reg ack_prev_ff;
	reg pend_ff;
	reg push_pend_ff;
	reg [ADDR_W-1:0] push_addr_ff;
	reg snoop_q_ff;
	reg [ADDR_W-1:0] snoop_a_ff;

	// wishbone decode
	wire wb_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
	// a write lands on the edge at which the master sees ack
	wire wb_wr = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & wb_sel_in[0];
	// bus-side events
	wire err_evt = (state_ff == S_DATA) & bus_error_ack_in;
	wire last_beat = transfer_ack_in & (beats_ff == 3'h1);
	wire snoop_qual = transfer_start_in & global_indication_in & addr_oe_n_out;
	wire push_trig = snoop_q_ff & snoop_hit_in & snoop_modified_in;

	// transfer type selection
	function [3:0] bes_tt;
		input rd;
		input read_with_intent_to_modify;
		input burst;
		begin
			if (!rd)
				bes_tt = burst ? `BES_TT_PUSH : `BES_TT_WRITE_SB;
			else if (read_with_intent_to_modify)
				bes_tt = `BES_TT_READ_WITH_INTENT_TO_MODIFY;
			else
				bes_tt = `BES_TT_READ;
		end
	endfunction

	// bus sequencer next state
	always @*
	begin
		nxt_state = state_ff;
		case (state_ff)
			S_IDLE:
				// after a bus error nothing more runs until reset
				if (err_ff)
					nxt_state = S_IDLE;
				else if (push_pend_ff)
					nxt_state = S_PUSHA;
				else if (req_valid_in && !(req_clean_hit_in && !req_coherent_in && !req_read_in))
					nxt_state = S_ADDR;
			S_ADDR: nxt_state = S_WAITDG;
			S_WAITDG:
				if (data_bus_grant_in)
					nxt_state = S_DATA;
			// an error ends the tenure at once; later acks find the sequencer idle
			S_DATA:
				if (err_evt)
					nxt_state = S_IDLE;
				else if (last_beat)
					nxt_state = S_IDLE;
			S_PUSHA: nxt_state = S_PUSHD;
			// the push waits for its data bus grant like any other tenure
			S_PUSHD:
				if (data_bus_grant_in)
					nxt_state = S_DATA;
			default: nxt_state = S_IDLE;
		endcase
	end

	// sequencer state register
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
			state_ff <= S_IDLE;
		else
			state_ff <= nxt_state;
	end

	// beat counter and direction of the tenure being run
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			beats_ff <= 3'h0;
			rd_ff <= 1'b0;
		end
		else if (nxt_state == S_ADDR)
		begin
			rd_ff <= req_read_in;
			beats_ff <= req_burst_in ? `BES_BURST_BEATS : `BES_SINGLE_BEATS;
		end
		else if (nxt_state == S_PUSHA)
		begin
			// a snoop push is always a four-beat write
			rd_ff <= 1'b0;
			beats_ff <= `BES_BURST_BEATS;
		end
		else if (state_ff == S_DATA && transfer_ack_in && !err_evt)
			beats_ff <= beats_ff - 3'h1;
	end

	// read data pipeline: a beat is forwarded once data retry stays low
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			ack_prev_ff <= 1'b0;
			pend_ff <= 1'b0;
		end
		else
		begin
			// writes never look at data retry
			ack_prev_ff <= (state_ff == S_DATA) & transfer_ack_in & rd_ff;
			// a retried beat waits here until retry is negated, so it counts once
			pend_ff <= (ack_prev_ff | pend_ff) & data_retry_in & rd_ff;
		end
	end

	// bus error: sticky error, then checkstop or machine check per control
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			err_ff <= 1'b0;
			machine_check_out <= 1'b0;
			checkstop_out <= 1'b0;
		end
		else if (err_evt)
		begin
			// recovery only by reset; no address is kept
			err_ff <= 1'b1;
			if (ctrl_ff[`BES_CTRL_CSE])
				checkstop_out <= 1'b1;
			else if (ctrl_ff[`BES_CTRL_MCE])
				machine_check_out <= 1'b1;
		end
	end

	// data beat forwarding; earlier beats are kept even after an error
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			beat_valid_out <= 1'b0;
			txn_done_out <= 1'b0;
		end
		else
		begin
			beat_valid_out <= (ack_prev_ff | pend_ff) & ~data_retry_in & rd_ff;
			// a push ends in S_DATA as well, so it reports done too
			txn_done_out <= (state_ff == S_DATA) & (last_beat | err_evt);
		end
	end

	// address tenure drive and release
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			addr_out <= {ADDR_W{1'b0}};
			addr_oe_n_out <= 1'b1;
			transfer_start_out <= 1'b0;
			transfer_start_oe_n_out <= 1'b1;
			transfer_type_bits_out <= 4'h0;
			tt_oe_n_out <= 1'b1;
			burst_out <= 1'b0;
			global_indication_out <= 1'b0;
			global_indication_oe_n_out <= 1'b1;
			replaced_way_code_out <= 3'h0;
		end
		else
		begin
			transfer_start_out <= (nxt_state == S_ADDR) | (nxt_state == S_PUSHA);
			if (nxt_state == S_ADDR)
			begin
				addr_out <= req_addr_in;
				transfer_type_bits_out <= bes_tt(req_read_in, req_read_with_intent_to_modify_in, req_burst_in);
				burst_out <= req_burst_in;
				global_indication_out <= req_coherent_in & ~req_no_tlb_in;
				replaced_way_code_out <= (req_read_in & req_burst_in) ? req_way_in : 3'h0;
			end
			else if (nxt_state == S_PUSHA)
			begin
				addr_out <= push_addr_ff;
				transfer_type_bits_out <= bes_tt(1'b0, 1'b0, 1'b1);
				burst_out <= 1'b1;
				global_indication_out <= 1'b0;
				replaced_way_code_out <= 3'h0;
			end
			// high impedance outside the address tenure
			addr_oe_n_out <= ~((nxt_state == S_ADDR) | (nxt_state == S_PUSHA));
			transfer_start_oe_n_out <= ~((nxt_state == S_ADDR) | (nxt_state == S_PUSHA));
			tt_oe_n_out <= ~((nxt_state == S_ADDR) | (nxt_state == S_PUSHA));
			global_indication_oe_n_out <= ~((nxt_state == S_ADDR) | (nxt_state == S_PUSHA));
		end
	end

	// data bus busy during data tenure, dropped on error
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			data_bus_busy_out <= 1'b0;
			data_bus_busy_oe_n_out <= 1'b1;
		end
		else
		begin
			// busy and its enable share the data tenure window
			data_bus_busy_out <= (nxt_state == S_DATA);
			data_bus_busy_oe_n_out <= ~(nxt_state == S_DATA);
		end
	end

	// snoop qualification and tag port
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			snoop_q_ff <= 1'b0;
			snoop_a_ff <= {ADDR_W{1'b0}};
			snoop_lookup_out <= 1'b0;
			snoop_addr_out <= {ADDR_W{1'b0}};
			snoop_inval_out <= 1'b0;
			address_retry_out <= 1'b0;
			address_retry_oe_n_out <= 1'b1;
			push_pend_ff <= 1'b0;
			push_addr_ff <= {ADDR_W{1'b0}};
		end
		else
		begin
			snoop_q_ff <= snoop_qual;
			snoop_a_ff <= addr_in;
			snoop_lookup_out <= snoop_qual;
			snoop_addr_out <= addr_in;
			// tag port answers in the same cycle as lookup
			snoop_inval_out <= snoop_q_ff & snoop_hit_in;
			address_retry_out <= push_trig;
			address_retry_oe_n_out <= ~push_trig;
			if (push_trig)
			begin
				push_pend_ff <= 1'b1;
				push_addr_ff <= snoop_a_ff;
			end
			else if (nxt_state == S_PUSHA)
				push_pend_ff <= 1'b0;
		end
	end

	// control register and wishbone answer
	always @(posedge clk_sys_in)
	begin
		if (reset_in)
		begin
			ctrl_ff <= `BES_CTRL_RST;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_out <= wb_req;
			// control write, taken with ack
			if (wb_wr && wb_adr_in == `BES_REG_CTRL)
				ctrl_ff <= wb_dat_in[1:0];
			wb_dat_out <= 32'h0000_0000;
			if (wb_req && !wb_we_in)
				case (wb_adr_in)
					`BES_REG_CTRL: wb_dat_out <= {30'h0, ctrl_ff};
					`BES_REG_STATUS: wb_dat_out <= {28'h0, state_ff != S_IDLE, err_ff, checkstop_out,
						machine_check_out};
					`BES_REG_TXN: wb_dat_out <= {24'h0, replaced_way_code_out, transfer_type_bits_out, burst_out};
					`BES_REG_SNOOP: wb_dat_out <= {31'h0, push_pend_ff};
					default: wb_dat_out <= 32'h0000_0000;
				endcase
		end
	end
endmodule // bes_core

// ---- design/bes_defines.vh ----
`ifndef BES_DEFINES_VH
`define BES_DEFINES_VH
// register byte offsets
`define BES_REG_CTRL 4'h0
`define BES_REG_STATUS 4'h4
`define BES_REG_TXN 4'h8
`define BES_REG_SNOOP 4'hC
// control register fields
`define BES_CTRL_MCE 0
`define BES_CTRL_CSE 1
// status register fields
`define BES_ST_MCHK 0
`define BES_ST_CSTOP 1
`define BES_ST_ERR 2
`define BES_ST_BUSY 3
// transfer type codes, bits 0..3
`define BES_TT_WRITE_SB 4'h1
`define BES_TT_WRITE_MASK 4'h7
`define BES_TT_READ 4'hA
`define BES_TT_READ_WITH_INTENT_TO_MODIFY 4'hE
`define BES_TT_PUSH 4'h6
// page attribute code for coherent write-back cacheable
`define BES_WIM_COHERENT 3'h1
// burst beats
`define BES_BURST_BEATS 3'h4
`define BES_SINGLE_BEATS 3'h1
// reset values
`define BES_CTRL_RST 2'h0
`endif
